// ===== design/psc_pkg.sv
// Package for the strap configuration latch: register map, strap pin indices,
// pull defaults, interface mode codes and timing.
// Assumes a 100 MHz APB clock and an active-low asynchronous chip reset.
package psc_pkg;

    // Register byte offsets on APB.
    localparam logic [7:0] PSC_REG_CTRL = 8'h00;
    localparam logic [7:0] PSC_REG_ADV  = 8'h04;
    localparam logic [7:0] PSC_REG_STAT = 8'h08;

    // Control register field positions.
    localparam int PSC_CTRL_DUPLEX_BIT  = 8;
    localparam int PSC_CTRL_ISOLATE_BIT = 10;
    localparam int PSC_CTRL_ANEG_BIT    = 12;
    localparam int PSC_CTRL_SPEED_BIT   = 13;

    // Advertisement register fields.
    localparam int PSC_ADV_CAP_LSB = 5;
    localparam int PSC_ADV_CAP_W   = 4;
    localparam int PSC_ADV_SEL_W   = 5;
    localparam logic [4:0] PSC_ADV_SELECTOR = 5'h01;
    localparam logic [3:0] PSC_ADV_CAP_100  = 4'hF;
    localparam logic [3:0] PSC_ADV_CAP_10   = 4'h3;

    // Status register field positions.
    localparam int PSC_STAT_ADDR_LSB  = 0;
    localparam int PSC_STAT_MODE_LSB  = 8;
    localparam int PSC_STAT_RSVD_BIT  = 11;
    localparam int PSC_STAT_FIBER_BIT = 12;
    localparam int PSC_STAT_FEF_BIT   = 13;
    localparam int PSC_STAT_DONE_BIT  = 15;

    // Strap pin indices within the strap pin vector.
    localparam int PSC_NUM_STRAPS  = 10;
    localparam int PSC_PIN_ADDR0   = 0;
    localparam int PSC_PIN_ADDR1   = 1;
    localparam int PSC_PIN_ADDR2   = 2;
    localparam int PSC_PIN_IFSEL0  = 3;
    localparam int PSC_PIN_IFSEL1  = 4;
    localparam int PSC_PIN_IFSEL2  = 5;
    localparam int PSC_PIN_ISOLATE = 6;
    localparam int PSC_PIN_RATE    = 7;
    localparam int PSC_PIN_DUPLEX  = 8;
    localparam int PSC_PIN_ANEG    = 9;
    localparam int PSC_SYNC_W      = 11;
    localparam int PSC_SYNC_FIBER  = 10;

    // Pull defaults of the strap pins and the fiber select.
    localparam logic [2:0] PSC_DEF_ADDR_LOW = 3'h1;
    localparam logic [1:0] PSC_ADDR_HIGH    = 2'h0;
    localparam logic [2:0] PSC_DEF_IFSEL    = 3'h0;
    localparam logic       PSC_DEF_ISOLATE  = 1'b0;
    localparam logic       PSC_DEF_SPEED    = 1'b1;
    localparam logic       PSC_DEF_HALF     = 1'b1;
    localparam logic       PSC_DEF_ANEG     = 1'b1;
    localparam logic       PSC_DEF_FEF      = 1'b1;
    localparam logic       PSC_DEF_FIBER    = 1'b0;

    // Interface select codes.
    typedef enum logic [2:0] {
        PSC_IF_MII      = 3'h0,
        PSC_IF_RMII     = 3'h1,
        PSC_IF_SMII     = 3'h2,
        PSC_IF_RSVD3    = 3'h3,
        PSC_IF_MII_PRE  = 3'h4,
        PSC_IF_RMII_B2B = 3'h5,
        PSC_IF_MII_B2B  = 3'h6,
        PSC_IF_RSVD7    = 3'h7
    } psc_if_mode_t;

    // Synchroniser depth and the time the strap levels must stay steady.
    localparam int PSC_SYNC_STAGES  = 3;
    localparam int PSC_CLK_PERIOD_NS = 10;
    localparam int PSC_SETTLE_NS    = 40;
    localparam int PSC_SETTLE_CYC   = (PSC_SETTLE_NS + PSC_CLK_PERIOD_NS - 1) / PSC_CLK_PERIOD_NS;
    localparam int PSC_CNT_W        = 4;

endpackage : psc_pkg

// ===== design/psc_strap_latch.sv
// Strap configuration latch: samples the strap pins after reset release, turns
// them into control settings and frees the pins for their normal output use.
// Assumes APB master on pclk; func_pin_data comes from the receive datapath.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - The three station address straps are captured after reset, giving an address from 0 to 7.
// - With the straps at their pull defaults the captured management address is 00001.
// - Address bits 4 and 3 are always zero and only bits 2 to 0 come from straps.
// - The interface select strap is captured, 000 is MII and default, 001 RMII, 010 SMII.
// - Code 100 is MII with preamble restore, 101 RMII back-to-back, 110 MII back-to-back, 011 and 111 reserved.
// - The isolate strap goes to control bit 10, high isolates and low is the default.
// - The rate strap goes to control bit 13, high is 100 Mbps and the default, low is 10 Mbps.
// - The rate strap also sets the speed capability bits of the advertisement register.
// - In fiber mode the rate strap instead captures far-end-fault enable, high and default enabling it.
// - The duplex strap goes to control bit 8, high is half duplex and default, low full duplex.
// - The auto-negotiation strap goes to control bit 12, high enables it and is the default.
// - In fiber mode auto-negotiation is forced off whatever the strap says.
// - Strap pins are inputs during reset and become normal outputs once the straps have been captured.
// - A low fiber select, the default, keeps the device in copper mode.
module psc_strap_latch
    import psc_pkg::*;
#(
    parameter int SETTLE_CYC = PSC_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Strap pins, shared with receive outputs
    input  wire logic [PSC_NUM_STRAPS-1:0] strap_in,
    output var  logic [PSC_NUM_STRAPS-1:0] strap_out,
    output var  logic [PSC_NUM_STRAPS-1:0] strap_oe,
    input  wire logic [PSC_NUM_STRAPS-1:0] func_pin_data,
    // Fiber select input
    input  wire logic        fiber_select,
    // Captured configuration
    output var  logic [4:0]  mgmt_addr,
    output var  logic [2:0]  if_mode,
    output var  logic        if_rmii,
    output var  logic        if_smii,
    output var  logic        back_to_back,
    output var  logic        preamble_restore,
    output var  logic        if_mode_reserved,
    output var  logic        fiber_mode,
    output var  logic        far_end_fault,
    output var  logic        isolate,
    output var  logic        speed_100,
    output var  logic        half_duplex,
    output var  logic        autoneg_enable,
    output var  logic [3:0]  adv_speed_cap,
    output var  logic        config_valid
);

    typedef enum logic [1:0] {
        PSC_ST_FILL   = 2'b00,
        PSC_ST_SETTLE = 2'b01,
        PSC_ST_DONE   = 2'b10
    } psc_state_t;

    psc_state_t           state;
    logic [PSC_CNT_W-1:0] count;
    logic                 capture;
    logic                 fiber_now;
    logic                 wr_ctrl;
    logic                 wr_adv;
    logic [31:0]          next_prdata;
    logic                 next_pslverr;

    psc_sync_if #(.W(PSC_SYNC_W)) sync_bus ();

    psc_strap_sync #(.W(PSC_SYNC_W)) u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_level ({fiber_select, strap_in}),
        .sync      (sync_bus.src)
    );

    // Interface mode classification, used for the decoded outputs.
    function automatic logic [4:0] psc_decode_mode(input logic [2:0] code);
        logic rmii;
        logic smii;
        logic b2b;
        logic pre;
        logic rsvd;
        rmii = 1'b0;
        smii = 1'b0;
        b2b  = 1'b0;
        pre  = 1'b0;
        rsvd = 1'b0;
        unique case (psc_if_mode_t'(code))
            PSC_IF_MII:      rmii = 1'b0;
            PSC_IF_RMII:     rmii = 1'b1;
            PSC_IF_SMII:     smii = 1'b1;
            PSC_IF_MII_PRE:  pre  = 1'b1;
            PSC_IF_RMII_B2B: begin
                rmii = 1'b1;
                b2b  = 1'b1;
            end
            PSC_IF_MII_B2B:  b2b  = 1'b1;
            PSC_IF_RSVD3,
            PSC_IF_RSVD7:    rsvd = 1'b1;
        endcase
        return {rsvd, pre, b2b, smii, rmii};
    endfunction : psc_decode_mode

    // Advertised speed capability follows the captured speed; a written control speed does not change it.
    function automatic logic [3:0] psc_adv_cap(input logic fast);
        return fast ? PSC_ADV_CAP_100 : PSC_ADV_CAP_10;
    endfunction : psc_adv_cap

    // Capture waits for the synchroniser to fill, then for the levels to hold
    // steady, so a pin still moving after reset release is not caught mid-edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PSC_ST_FILL;
            count <= '0;
        end else begin
            unique case (state)
                PSC_ST_FILL: begin
                    if (count == PSC_CNT_W'(PSC_SYNC_STAGES - 1)) begin
                        state <= PSC_ST_SETTLE;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                PSC_ST_SETTLE: begin
                    if (!sync_bus.agree) begin
                        count <= '0;
                    end else if (count == PSC_CNT_W'(SETTLE_CYC - 1)) begin
                        state <= PSC_ST_DONE;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                PSC_ST_DONE: count <= count;
                default: begin
                    state <= PSC_ST_FILL;
                    count <= '0;
                end
            endcase
        end
    end

    assign capture   = (state == PSC_ST_SETTLE) && sync_bus.agree &&
                       (count == PSC_CNT_W'(SETTLE_CYC - 1));
    assign fiber_now = sync_bus.level[PSC_SYNC_FIBER];

    // Pins stay undriven until the straps are taken; only then the receive
    // data path owns them. The pulls or external strap resistors set the levels meanwhile.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_oe     <= '0;
            strap_out    <= '0;
            config_valid <= 1'b0;
        end else begin
            strap_oe     <= (capture || config_valid) ? '1 : '0;
            strap_out    <= func_pin_data;
            config_valid <= config_valid | capture;
        end
    end

    // Straps fixed for the whole run: address, interface mode, fiber, far-end fault.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mgmt_addr        <= {PSC_ADDR_HIGH, PSC_DEF_ADDR_LOW};
            if_mode          <= PSC_DEF_IFSEL;
            {if_mode_reserved, preamble_restore, back_to_back, if_smii, if_rmii} <= '0;
            fiber_mode       <= PSC_DEF_FIBER;
            far_end_fault    <= 1'b0;
        end else if (capture) begin
            mgmt_addr <= {PSC_ADDR_HIGH,
                          sync_bus.level[PSC_PIN_ADDR2],
                          sync_bus.level[PSC_PIN_ADDR1],
                          sync_bus.level[PSC_PIN_ADDR0]};
            if_mode <= sync_bus.level[PSC_PIN_IFSEL2:PSC_PIN_IFSEL0];
            {if_mode_reserved, preamble_restore, back_to_back, if_smii, if_rmii} <=
                psc_decode_mode(sync_bus.level[PSC_PIN_IFSEL2:PSC_PIN_IFSEL0]);
            fiber_mode    <= fiber_now;
            far_end_fault <= fiber_now & sync_bus.level[PSC_PIN_RATE];
        end
    end

    // APB write strobes take effect only at the access edge.
    assign wr_ctrl = psel && penable && pready && pwrite && (paddr == PSC_REG_CTRL) && config_valid;
    assign wr_adv  = psel && penable && pready && pwrite && (paddr == PSC_REG_ADV) && config_valid;

    // Control bits: loaded from straps once, then software may change them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isolate        <= PSC_DEF_ISOLATE;
            speed_100      <= PSC_DEF_SPEED;
            half_duplex    <= PSC_DEF_HALF;
            autoneg_enable <= PSC_DEF_ANEG;
        end else if (capture) begin
            isolate     <= sync_bus.level[PSC_PIN_ISOLATE];
            // Fiber runs only at 100 Mbps, so the rate pin is not a speed there.
            speed_100   <= fiber_now | sync_bus.level[PSC_PIN_RATE];
            half_duplex <= sync_bus.level[PSC_PIN_DUPLEX];
            autoneg_enable <= ~fiber_now & sync_bus.level[PSC_PIN_ANEG];
        end else if (wr_ctrl) begin
            isolate        <= pwdata[PSC_CTRL_ISOLATE_BIT];
            speed_100      <= fiber_mode | pwdata[PSC_CTRL_SPEED_BIT];
            half_duplex    <= pwdata[PSC_CTRL_DUPLEX_BIT];
            autoneg_enable <= ~fiber_mode & pwdata[PSC_CTRL_ANEG_BIT];
        end
    end

    // Advertised speed capability.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adv_speed_cap <= PSC_ADV_CAP_100;
        end else if (capture) begin
            adv_speed_cap <= psc_adv_cap(fiber_now | sync_bus.level[PSC_PIN_RATE]);
        end else if (wr_adv) begin
            adv_speed_cap <= pwdata[PSC_ADV_CAP_LSB +: PSC_ADV_CAP_W];
        end
    end

    // Read data is prepared in the setup cycle and answered in the first access cycle.
    always_comb begin
        next_prdata  = '0;
        next_pslverr = 1'b0;
        unique case (paddr)
            PSC_REG_CTRL: begin
                next_prdata[PSC_CTRL_DUPLEX_BIT]  = half_duplex;
                next_prdata[PSC_CTRL_ISOLATE_BIT] = isolate;
                next_prdata[PSC_CTRL_ANEG_BIT]    = autoneg_enable;
                next_prdata[PSC_CTRL_SPEED_BIT]   = speed_100;
            end
            PSC_REG_ADV: begin
                next_prdata[PSC_ADV_SEL_W-1:0] = PSC_ADV_SELECTOR;
                next_prdata[PSC_ADV_CAP_LSB +: PSC_ADV_CAP_W] = adv_speed_cap;
            end
            PSC_REG_STAT: begin
                next_prdata[PSC_STAT_ADDR_LSB +: 5] = mgmt_addr;
                next_prdata[PSC_STAT_MODE_LSB +: 3] = if_mode;
                next_prdata[PSC_STAT_RSVD_BIT]      = if_mode_reserved;
                next_prdata[PSC_STAT_FIBER_BIT]     = fiber_mode;
                next_prdata[PSC_STAT_FEF_BIT]       = far_end_fault;
                next_prdata[PSC_STAT_DONE_BIT]      = config_valid;
            end
            default: next_pslverr = 1'b1;
        endcase
        if (pwrite && paddr == PSC_REG_STAT) begin
            next_pslverr = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? '0 : next_prdata;
            pslverr <= next_pslverr;
        end else begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end
    end

endmodule : psc_strap_latch
`default_nettype wire

// ===== design/psc_strap_sync.sv
// Three-stage synchroniser for the strap pins and the fiber select input.
// Assumes the pins are asynchronous to pclk; reports when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module psc_strap_sync
    import psc_pkg::*;
#(
    parameter int W = PSC_SYNC_W
) (
    // Clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Raw pin levels
    input  wire logic [W-1:0] pin_level,
    // Synchronised levels
    psc_sync_if.src     sync
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1[g] <= 1'b0;
                    stage2[g] <= 1'b0;
                    stage3[g] <= 1'b0;
                end else begin
                    stage1[g] <= pin_level[g];
                    stage2[g] <= stage1[g];
                    stage3[g] <= stage2[g];
                end
            end
        end
    endgenerate

    assign sync.level = stage3;
    assign sync.agree = (stage2 == stage3);

endmodule : psc_strap_sync
`default_nettype wire

// ===== design/psc_sync_if.sv
// Carries synchronised strap levels from the synchroniser to the latch core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface psc_sync_if #(parameter int W = 11);
    logic [W-1:0] level;
    logic         agree;
    modport src (output level, output agree);
    modport dst (input level, input agree);
endinterface : psc_sync_if
`default_nettype wire

// ===== tb/psc_strap_board.sv
// Board side of the strap pins: internal pull levels, external strap resistors
// and the fiber select level. Assumes the bench changes straps in reset and once after capture, for the hold check.
`timescale 1ns/1ps
`default_nettype none
module psc_strap_board
    import psc_pkg::*;
(
    // Device side of the pins
    input  wire logic [PSC_NUM_STRAPS-1:0] strap_out,
    input  wire logic [PSC_NUM_STRAPS-1:0] strap_oe,
    // Bench control of the board
    input  wire logic                      strap_drv,
    input  wire logic [PSC_NUM_STRAPS-1:0] strap_lvl,
    input  wire logic                      fiber_lvl,
    // Resolved pin levels
    output var  logic [PSC_NUM_STRAPS-1:0] strap_in,
    output var  logic                      fiber_select
);
    localparam logic [PSC_NUM_STRAPS-1:0] PULLS = {PSC_DEF_ANEG, PSC_DEF_HALF, PSC_DEF_SPEED,
                                                   PSC_DEF_ISOLATE, PSC_DEF_IFSEL, PSC_DEF_ADDR_LOW};
    always_comb begin
        for (int i = 0; i < PSC_NUM_STRAPS; i++) begin
            if (strap_oe[i]) begin
                strap_in[i] = strap_out[i];
            end else if (strap_drv) begin
                // Strong resistors overrule a MAC input that idles high in reset.
                strap_in[i] = strap_lvl[i];
            end else begin
                strap_in[i] = PULLS[i];
            end
        end
    end
    assign fiber_select = fiber_lvl;
endmodule : psc_strap_board
`default_nettype wire

// ===== tb/psc_strap_latch_chk.sv
// Concurrent checks on the strap latch, seeing only its top-level ports.
// Assumes one pclk domain and pins held steady from reset until capture.
`timescale 1ns/1ps
`default_nettype none
module psc_strap_latch_chk
    import psc_pkg::*;
#(
    parameter int SETTLE_CYC = PSC_SETTLE_CYC
) (
    // Clock, reset and APB
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    // Pins
    input wire logic [PSC_NUM_STRAPS-1:0] strap_in,
    input wire logic [PSC_NUM_STRAPS-1:0] strap_oe,
    input wire logic                      fiber_select,
    // Captured configuration
    input wire logic [4:0]                mgmt_addr,
    input wire logic [2:0]                if_mode,
    input wire logic                      if_rmii,
    input wire logic                      if_smii,
    input wire logic                      back_to_back,
    input wire logic                      preamble_restore,
    input wire logic                      if_mode_reserved,
    input wire logic                      fiber_mode,
    input wire logic                      far_end_fault,
    input wire logic                      isolate,
    input wire logic                      speed_100,
    input wire logic                      half_duplex,
    input wire logic                      autoneg_enable,
    input wire logic [3:0]                adv_speed_cap,
    input wire logic                      config_valid
);
    // Latest capture edge after the fill phase, plus the edge at which the registered config_valid is seen.
    localparam int CAP_MAX = SETTLE_CYC + 1;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_release;
        $rose(presetn);
    endsequence
    sequence s_capture;
        $rose(config_valid);
    endsequence
    property p_capture;
        s_capture |-> mgmt_addr[2:0] == $past(strap_in[2:0], 2) && if_mode == $past(strap_in[5:3], 2)
            && isolate == $past(strap_in[6], 2) && half_duplex == $past(strap_in[8], 2)
            && fiber_mode == $past(fiber_select, 2)
            && (fiber_mode ? (speed_100 && far_end_fault == $past(strap_in[7], 2))
                : (speed_100 == $past(strap_in[7], 2) && autoneg_enable == $past(strap_in[9], 2)));
    endproperty
    AST_ADDR_TOP: assert property (mgmt_addr[4:3] == 2'h0) else $error("address top bits set");
    AST_CAPTURE: assert property (p_capture) else $error("captured value differs from pins");
    AST_DECODE: assert property (config_valid |-> if_rmii == (if_mode == 3'h1 || if_mode == 3'h5)
        && if_smii == (if_mode == 3'h2) && back_to_back == (if_mode == 3'h5 || if_mode == 3'h6)
        && preamble_restore == (if_mode == 3'h4) && if_mode_reserved == (if_mode == 3'h3 || if_mode == 3'h7))
        else $error("interface mode decode wrong");
    AST_ADV_CAP: assert property (s_capture |-> adv_speed_cap == (speed_100 ? PSC_ADV_CAP_100 : PSC_ADV_CAP_10))
        else $error("advertised speed differs");
    AST_FIBER_ANEG: assert property (fiber_mode |-> !autoneg_enable && speed_100) else $error("fiber autoneg on");
    AST_HOLD: assert property (config_valid && $past(config_valid) |-> $stable(mgmt_addr) && $stable(if_mode)
        && $stable(fiber_mode) && $stable(far_end_fault)) else $error("captured value moved");
    AST_PIN_OE: assert property (strap_oe == {PSC_NUM_STRAPS{config_valid}}) else $error("pin enable wrong");
    AST_SETTLE: assert property (s_release |-> !config_valid [*3] ##[1:CAP_MAX] config_valid)
        else $error("capture time wrong");
    AST_APB_ANSWER: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    AST_BAD_ADDR: assert property (psel && !penable && paddr > PSC_REG_STAT |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule : psc_strap_latch_chk
bind psc_strap_latch psc_strap_latch_chk #(.SETTLE_CYC(SETTLE_CYC)) u_psc_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .strap_in(strap_in), .strap_oe(strap_oe), .fiber_select(fiber_select),
    .mgmt_addr(mgmt_addr), .if_mode(if_mode), .if_rmii(if_rmii), .if_smii(if_smii), .back_to_back(back_to_back),
    .preamble_restore(preamble_restore), .if_mode_reserved(if_mode_reserved), .fiber_mode(fiber_mode),
    .far_end_fault(far_end_fault), .isolate(isolate), .speed_100(speed_100), .half_duplex(half_duplex),
    .autoneg_enable(autoneg_enable), .adv_speed_cap(adv_speed_cap), .config_valid(config_valid));
`default_nettype wire

// ===== tb/tb_psc_strap_latch.sv
// Bench: random strap sets over repeated resets, every interface
// code, a hold check after capture and APB accesses.
`timescale 1ns/1ps
`default_nettype none
module tb_psc_strap_latch
    import psc_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, fiber_select, fib = 1'b0, drv = 1'b0;
    logic [9:0]  strap_in, strap_out, strap_oe, lvl = 10'h000, func = 10'h000;
    logic [4:0]  mgmt_addr;
    logic [2:0]  if_mode;
    logic [3:0]  adv_speed_cap;
    logic        if_rmii, if_smii, back_to_back, preamble_restore, if_mode_reserved, fiber_mode;
    logic        far_end_fault, isolate, speed_100, half_duplex, autoneg_enable, config_valid;
    int          n_errors = 0;
    int          compares = 0;
    always #5 pclk = ~pclk;
    psc_strap_latch #(.SETTLE_CYC(4)) i_psc_strap_latch (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_in(strap_in),
        .strap_out(strap_out), .strap_oe(strap_oe), .func_pin_data(func), .fiber_select(fiber_select),
        .mgmt_addr(mgmt_addr), .if_mode(if_mode), .if_rmii(if_rmii), .if_smii(if_smii),
        .back_to_back(back_to_back), .preamble_restore(preamble_restore), .if_mode_reserved(if_mode_reserved),
        .fiber_mode(fiber_mode), .far_end_fault(far_end_fault), .isolate(isolate), .speed_100(speed_100),
        .half_duplex(half_duplex), .autoneg_enable(autoneg_enable), .adv_speed_cap(adv_speed_cap),
        .config_valid(config_valid));
    psc_strap_board i_psc_strap_board (.strap_out(strap_out), .strap_oe(strap_oe), .strap_drv(drv),
        .strap_lvl(lvl), .fiber_lvl(fib), .strap_in(strap_in), .fiber_select(fiber_select));
    function automatic logic [4:0] exp_dec(input logic [2:0] m);
        exp_dec = {m == 3'h1 || m == 3'h5, m == 3'h2, m == 3'h5 || m == 3'h6, m == 3'h4, m == 3'h3 || m == 3'h7};
    endfunction : exp_dec
    function automatic logic [31:0] exp_cfg(input logic [9:0] s, input logic f);
        exp_cfg = 32'({f, f & s[7], s[6], s[7] | f, s[8], s[9] & ~f, (s[7] | f) ? 4'hF : 4'h3});
    endfunction : exp_cfg
    function automatic logic [31:0] exp_stat(input logic [9:0] s, input logic f);
        exp_stat = 32'(s[2:0]) | (32'(s[5:3]) << 8) | (32'(exp_dec(s[5:3]) & 5'h01) << 11)
            | (32'(f) << 12) | (32'(f & s[7]) << 13) | 32'h8000;
    endfunction : exp_stat
    function automatic logic [31:0] exp_ctrl(input logic [9:0] s, input logic f);
        exp_ctrl = (32'(s[8]) << 8) | (32'(s[6]) << 10) | (32'(s[9] & ~f) << 12) | (32'(s[7] | f) << 13);
    endfunction : exp_ctrl
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    initial begin
        repeat (6000) @(posedge pclk);
        n_errors++;
        complete_run();
    end
    initial begin
        logic [31:0] rd;
        logic        err;
        logic [9:0]  s;
        void'($urandom(32'hF151));
        for (int i = 0; i < 17; i++) begin
            // Pass 0 leaves the pins on their pulls.
            s = (i == 0) ? 10'h381 : 10'($urandom());
            if (i > 0 && i < 9) s[5:3] = 3'(i - 1);
            @(posedge pclk);
            presetn <= 1'b0;
            drv <= (i != 0);
            lvl <= s;
            fib <= (i > 8) ? 1'($urandom()) : 1'b0;
            repeat (6) @(posedge pclk);
            presetn <= 1'b1;
            repeat (12) @(posedge pclk);
            chk(32'(mgmt_addr), 32'(s[2:0]));
            chk(32'(if_mode), 32'(s[5:3]));
            chk(32'({if_rmii, if_smii, back_to_back, preamble_restore, if_mode_reserved}), 32'(exp_dec(s[5:3])));
            chk(32'({fiber_mode, far_end_fault, isolate, speed_100, half_duplex, autoneg_enable, adv_speed_cap}),
                exp_cfg(s, fib));
            apb(1'b0, PSC_REG_STAT, 32'h0, rd, err);
            chk(rd, exp_stat(s, fib));
            apb(1'b0, PSC_REG_CTRL, 32'h0, rd, err);
            chk(rd, exp_ctrl(s, fib));
            apb(1'b0, PSC_REG_ADV, 32'h0, rd, err);
            chk(rd, 32'h1 | (32'((s[7] | fib) ? 4'hF : 4'h3) << 5));
        end
        func <= 10'($urandom());
        repeat (2) @(posedge pclk);
        chk(32'(strap_in), 32'(func));
        fib <= ~fib;
        lvl <= ~s;
        repeat (10) @(posedge pclk);
        chk(32'({fiber_mode, far_end_fault, isolate, speed_100, half_duplex, autoneg_enable, adv_speed_cap}),
            exp_cfg(s, ~fib));
        apb(1'b1, PSC_REG_CTRL, 32'h0, rd, err);
        apb(1'b0, PSC_REG_CTRL, 32'h0, rd, err);
        chk(rd, 32'(!fib) << 13);
        apb(1'b1, PSC_REG_ADV, 32'(s) << 5, rd, err);
        apb(1'b0, PSC_REG_ADV, 32'h0, rd, err);
        chk(rd, 32'h1 | 32'(s[3:0]) << 5);
        apb(1'b1, PSC_REG_STAT, 32'hFFFF_FFFF, rd, err);
        chk(32'(err), 32'h1);
        apb(1'b0, 8'h0C, 32'h0, rd, err);
        chk({rd[30:0], err}, 32'h1);
        complete_run();
    end
endmodule : tb_psc_strap_latch
`default_nettype wire
